// [logic/smf_pkg.sv]
/*
  Shared constants and types for the four-select serial master.
  Assumes a single system clock; used by the master, its port checker and the bench.
*/
package smf_pkg;

  // ********************************
  // widths and counts
  // ********************************
  localparam int unsigned DATA_W     = 32;  // longest character
  localparam int unsigned LEN_W      = 5;   // char length minus one, 1..32 bits
  localparam int unsigned FRAME_W    = 12;  // frame length minus one, 1..4096 chars
  localparam int unsigned DIV_W      = 16;  // bit clock half-period divider
  localparam int unsigned CS_N       = 4;   // slave selects
  localparam int unsigned CS_SEL_W   = 2;
  localparam int unsigned DLY_W      = 2;   // select-to-data delay, 0..3 bit clocks
  localparam int unsigned FIFO_DEPTH = 16;

  // ********************************
  // reset values
  // ********************************
  localparam logic [CS_N-1:0] CS_RESET   = 4'hf;  // all selects released, active low
  localparam logic            SCLK_RESET = 1'b0;
  localparam logic            TX_RESET   = 1'b0;

  // settings held steady for one frame
  typedef struct packed {
    logic [CS_SEL_W-1:0] sel;
    logic [LEN_W-1:0]    len_m1;
    logic [FRAME_W-1:0]  frame_m1;
    logic [DLY_W-1:0]    delay;
    logic                cpol;
    logic                cpha;
    logic                cs_high;
    logic                loopback;
  } smf_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_LEAD,
    ST_SHIFT,
    ST_TAIL
  } smf_state_t;

endpackage

// [logic/smf_fifo.sv]
/*
  Synchronous FIFO with registered read data and a registered ready.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module smf_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             resetn,    // sync reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // write data
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // head word
  output logic                  out_valid, // head word present
  input  wire logic             out_ready  // consumer takes head
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             ov_q, ov_d, rdy_q, rdy_d;
  logic             push, pop;

  always_comb begin
    push  = in_valid && rdy_q;
    // refill the output register whenever it is empty or being taken
    pop   = (cnt_q != '0) && (!ov_q || out_ready);
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    od_d  = pop ? mem[rp_q] : od_q;
    ov_d  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    rdy_d = cnt_d != (AW+1)'(DEPTH);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      od_q  <= '0;
      ov_q  <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      od_q  <= od_d;
      ov_q  <= ov_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready  = rdy_q;
  assign out_data  = od_q;
  assign out_valid = ov_q;
endmodule

// [logic/smf_spi_master.sv]
/*
  Four-select serial master: shifts characters of 1..32 bits out and in,
  frames of 1..4096 characters, bit clock from a programmable divider.
  Assumes the processor writes transmit words into the port and reads
  received words from it; all inputs except the receive pin are on sys_clk.
*/
`timescale 1ns/1ps
module smf_spi_master #(
  parameter int unsigned FIFO_DEPTH = smf_pkg::FIFO_DEPTH
) (
  input  wire logic                         sys_clk,               // 125 MHz system clock
  input  wire logic                         resetn,                // sync reset, active low
  input  wire logic [smf_pkg::DIV_W-1:0]    clk_div,               // half bit period minus one, sys clocks
  input  wire logic [smf_pkg::LEN_W-1:0]    char_len_m1,           // character length minus one
  input  wire logic [smf_pkg::FRAME_W-1:0]  frame_len_m1,          // characters per frame minus one
  input  wire logic [smf_pkg::CS_SEL_W-1:0] cs_sel,                // which slave to address
  input  wire logic [smf_pkg::CS_N-1:0]     cs_active_high,        // per select: 1 active high, 0 active low
  input  wire logic [smf_pkg::CS_N-1:0]     clock_polarity_select, // per select idle clock level
  input  wire logic [smf_pkg::CS_N-1:0]     clock_phase_select,    // per select: 1 launch on leading edge
  input  wire logic [smf_pkg::DLY_W-1:0]    cs_delay,              // select-to-data bit clocks
  input  wire logic                         loopback,              // internal loopback
  input  wire logic                         char_irq_en,           // enable character interrupt
  input  wire logic                         start,                 // start frame pulse
  input  wire logic [smf_pkg::DATA_W-1:0]   tx_data,               // transmit word, right aligned
  input  wire logic                         tx_valid,              // transmit word offered
  output logic                              tx_ready,              // transmit buffer has room
  output logic      [smf_pkg::DATA_W-1:0]   rx_data_q,             // last received character
  output logic                              rx_valid_q,            // received character pulse
  output logic                              char_irq_q,            // character done interrupt pulse
  output logic                              busy_q,                // frame in progress
  output logic                              spi_clk_q,             // bit clock pin
  output logic                              spi_tx_q,              // transmit data pin
  output logic      [smf_pkg::CS_N-1:0]     slave_select_lines_q,  // select pins
  input  wire logic                         spi_rx                 // receive data pin
);

  // ********************************
  // transmit buffer
  // ********************************
  logic [smf_pkg::DATA_W-1:0] fifo_data;
  logic                       fifo_valid;
  logic                       fifo_take;

  // processor writes words here; no DMA request exists
  smf_fifo #(
    .WIDTH (smf_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // ********************************
  // receive pin synchroniser
  // ********************************
  logic rx_s1_q, rx_s2_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
    end else begin
      rx_s1_q <= spi_rx;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ********************************
  // frame sequencer
  // ********************************
  smf_pkg::smf_state_t        st_q, st_d;
  smf_pkg::smf_cfg_t          cfg_q, cfg_d;
  logic [smf_pkg::DIV_W-1:0]  div_q, div_d;
  logic                       ph_q, ph_d;         // 0 idle half, 1 after leading edge
  logic [smf_pkg::LEN_W-1:0]  bit_q, bit_d;
  logic [smf_pkg::FRAME_W-1:0] chr_q, chr_d;
  logic [2:0]                 lead_q, lead_d;     // half periods of select lead
  logic [smf_pkg::DATA_W-1:0] tsh_q, tsh_d, rsh_q, rsh_d;
  logic [smf_pkg::DATA_W-1:0] rxd_d;
  logic                       rxv_d, irq_d, busy_d, sclk_d, stx_d;
  logic [smf_pkg::CS_N-1:0]   cs_d;
  logic                       tick, rx_bit, last_bit, char_done, sel_on;

  function automatic logic [smf_pkg::CS_N-1:0] cs_levels(
    input logic [smf_pkg::CS_SEL_W-1:0] sel,
    input logic                         on,
    input logic [smf_pkg::CS_N-1:0]     high
  );
    logic [smf_pkg::CS_N-1:0] lv;
    lv = ~high;
    if (on) begin
      lv[sel] = high[sel];
    end
    return lv;
  endfunction

  always_comb begin
    st_d     = st_q;
    cfg_d    = cfg_q;
    div_d    = div_q;
    ph_d     = ph_q;
    bit_d    = bit_q;
    chr_d    = chr_q;
    lead_d   = lead_q;
    tsh_d    = tsh_q;
    rsh_d    = rsh_q;
    rxd_d    = rx_data_q;
    rxv_d    = 1'b0;
    irq_d    = 1'b0;
    fifo_take = 1'b0;
    char_done = 1'b0;
    sel_on   = 1'b1;
    // loopback takes the pin value back without touching the rx pin
    rx_bit   = cfg_q.loopback ? spi_tx_q : rx_s2_q;
    last_bit = bit_q == cfg_q.len_m1;
    // divider runs only while a frame is active
    tick     = div_q == clk_div;
    div_d    = (st_q == smf_pkg::ST_IDLE || st_q == smf_pkg::ST_LOAD || tick) ? '0 : div_q + 1'b1;

    unique case (st_q)
      smf_pkg::ST_IDLE: begin
        sel_on = 1'b0;
        if (start) begin
          cfg_d.sel      = cs_sel;
          cfg_d.len_m1   = char_len_m1;
          cfg_d.frame_m1 = frame_len_m1;
          cfg_d.delay    = cs_delay;
          cfg_d.cpol     = clock_polarity_select[cs_sel];
          cfg_d.cpha     = clock_phase_select[cs_sel];
          cfg_d.cs_high  = cs_active_high[cs_sel];
          cfg_d.loopback = loopback;
          chr_d          = '0;
          lead_d         = {cs_delay, 1'b0};
          st_d           = smf_pkg::ST_LOAD;
        end
      end
      smf_pkg::ST_LOAD: begin
        // select held and clock idle while waiting for the processor
        if (fifo_valid) begin
          fifo_take = 1'b1;
          tsh_d     = fifo_data;
          rsh_d     = '0;
          bit_d     = '0;
          ph_d      = 1'b0;
          st_d      = (lead_q != '0) ? smf_pkg::ST_LEAD : smf_pkg::ST_SHIFT;
        end
      end
      smf_pkg::ST_LEAD: begin
        if (tick) begin
          lead_d = lead_q - 1'b1;
          if (lead_q == 3'h1) begin
            st_d = smf_pkg::ST_SHIFT;
          end
        end
      end
      smf_pkg::ST_SHIFT: begin
        if (tick) begin
          ph_d = ~ph_q;
          if (!ph_q) begin
            // leading edge: sample in phase 0, launch in phase 1
            if (cfg_q.cpha) begin
              if (bit_q != '0) begin
                tsh_d = {tsh_q[smf_pkg::DATA_W-2:0], 1'b0};
              end
            end else begin
              rsh_d = {rsh_q[smf_pkg::DATA_W-2:0], rx_bit};
            end
          end else begin
            // trailing edge
            if (cfg_q.cpha) begin
              rsh_d = {rsh_q[smf_pkg::DATA_W-2:0], rx_bit};
            end else if (!last_bit) begin
              tsh_d = {tsh_q[smf_pkg::DATA_W-2:0], 1'b0};
            end
            bit_d = bit_q + 1'b1;
            if (last_bit) begin
              char_done = 1'b1;
            end
          end
        end
        if (char_done) begin
          rxd_d = cfg_q.cpha ? {rsh_q[smf_pkg::DATA_W-2:0], rx_bit} : rsh_q;
          rxv_d = 1'b1;
          irq_d = char_irq_en;
          lead_d = '0;
          chr_d = chr_q + 1'b1;
          st_d  = (chr_q == cfg_q.frame_m1) ? smf_pkg::ST_TAIL : smf_pkg::ST_LOAD;
        end
      end
      smf_pkg::ST_TAIL: begin
        // half a bit period of hold before the select lets go
        if (tick) begin
          st_d = smf_pkg::ST_IDLE;
        end
      end
    endcase

    busy_d = st_d != smf_pkg::ST_IDLE;
    // only this block drives the bit clock and selects
    sclk_d = (st_d == smf_pkg::ST_SHIFT) ? (cfg_d.cpol ^ ph_d) : cfg_d.cpol;
    cs_d   = cs_levels(cfg_d.sel, busy_d, cs_active_high);
    if (busy_d) begin
      cs_d[cfg_d.sel] = cfg_d.cs_high;
    end
    stx_d  = busy_d ? tsh_d[cfg_d.len_m1] : smf_pkg::TX_RESET;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q                 <= smf_pkg::ST_IDLE;
      cfg_q                <= '0;
      div_q                <= '0;
      ph_q                 <= 1'b0;
      bit_q                <= '0;
      chr_q                <= '0;
      lead_q               <= '0;
      tsh_q                <= '0;
      rsh_q                <= '0;
      rx_data_q            <= '0;
      rx_valid_q           <= 1'b0;
      char_irq_q           <= 1'b0;
      busy_q               <= 1'b0;
      spi_clk_q            <= smf_pkg::SCLK_RESET;
      spi_tx_q             <= smf_pkg::TX_RESET;
      slave_select_lines_q <= smf_pkg::CS_RESET;
    end else begin
      st_q                 <= st_d;
      cfg_q                <= cfg_d;
      div_q                <= div_d;
      ph_q                 <= ph_d;
      bit_q                <= bit_d;
      chr_q                <= chr_d;
      lead_q               <= lead_d;
      tsh_q                <= tsh_d;
      rsh_q                <= rsh_d;
      rx_data_q            <= rxd_d;
      rx_valid_q           <= rxv_d;
      char_irq_q           <= irq_d;
      busy_q               <= busy_d;
      spi_clk_q            <= sclk_d;
      spi_tx_q             <= stx_d;
      slave_select_lines_q <= cs_d;
    end
  end
endmodule

// [dv/smf_spi_master_monitor.sv]
/*
  Port checker for the four-select serial master.
  Assumes one clock, a synchronous active-low reset, and a bind from below.
*/
`timescale 1ns/1ps
module smf_spi_master_monitor (
  input wire logic                       sys_clk,              // clock
  input wire logic                       resetn,               // reset, low
  input wire logic [smf_pkg::DIV_W-1:0]  clk_div,              // divider
  input wire logic [smf_pkg::LEN_W-1:0]  char_len_m1,          // bits minus one
  input wire logic [smf_pkg::CS_N-1:0]   cs_active_high,       // select levels
  input wire logic                       char_irq_en,          // irq enable
  input wire logic                       start,                // start pulse
  input wire logic [smf_pkg::DATA_W-1:0] rx_data_q,            // rx word
  input wire logic                       rx_valid_q,           // rx pulse
  input wire logic                       char_irq_q,           // irq pulse
  input wire logic                       busy_q,               // busy
  input wire logic                       spi_clk_q,            // bit clock
  input wire logic [smf_pkg::CS_N-1:0]   slave_select_lines_q  // select pins
);
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // stable guard: idle levels follow the live input one cycle late
  a_idle_selects: assert property (
    !busy_q && $stable(cs_active_high) |-> slave_select_lines_q == ~cs_active_high) else $error("select not idle");
  a_single_select: assert property (
    busy_q |-> $countones(slave_select_lines_q ^ ~cs_active_high) <= 1) else $error("two selects active");
  a_start_busy: assert property (
    start && !busy_q |=> busy_q) else $error("start not taken");
  a_busy_cause: assert property (
    $rose(busy_q) |-> $past(start)) else $error("busy without start");
  a_clk_quiet: assert property (
    !busy_q && !start |=> $stable(spi_clk_q)) else $error("clock moved while idle");
  a_half_period: assert property (
    $changed(spi_clk_q) && clk_div >= 16'h0002 |=> $stable(spi_clk_q) [*2]) else $error("half period short");
  a_irq_with_rx: assert property (
    char_irq_q |-> rx_valid_q) else $error("irq without character");
  a_irq_enable: assert property (
    rx_valid_q |-> char_irq_q == $past(char_irq_en)) else $error("irq gating wrong");
  a_rx_width: assert property (
    rx_valid_q |-> ((rx_data_q >> char_len_m1) >> 1) == '0) else $error("rx upper bits set");
endmodule

bind smf_spi_master smf_spi_master_monitor u_smf_spi_master_monitor (
  .sys_clk(sys_clk), .resetn(resetn), .clk_div(clk_div), .char_len_m1(char_len_m1),
  .cs_active_high(cs_active_high), .char_irq_en(char_irq_en), .start(start), .rx_data_q(rx_data_q),
  .rx_valid_q(rx_valid_q), .char_irq_q(char_irq_q), .busy_q(busy_q), .spi_clk_q(spi_clk_q),
  .slave_select_lines_q(slave_select_lines_q));

// [dv/smf_slave_model.sv]
/*
  Behavioural serial slave that answers every character with one word.
  Assumes the bench hands it the selected line and that line's settings.
*/
`timescale 1ns/1ps
module smf_slave_model #(
  parameter logic [31:0] PAT = 32'h0000_0000
) (
  input wire logic       sclk,    // bit clock
  input wire logic       cs_line, // selected pin
  input wire logic       act_hi,  // its active level
  input wire logic       cpol,    // idle clock level
  input wire logic       cpha,    // phase
  input wire logic [4:0] len_m1,  // bits minus one
  output logic           miso     // reply pin
);
  // ********************************
  // reply shifter
  // ********************************
  int  pos;
  time t_on;
  wire on = (cs_line == act_hi);

  // unselected or before the first launch: flip, so no stale bit is read
  task automatic drive();
    if (on && pos >= 0) miso = PAT[int'(len_m1) - pos % (int'(len_m1) + 1)];
    else miso = ~miso;
  endtask

  initial begin
    miso = 1'b0;
    pos = 0;
    t_on = 0;
  end
  always @(on) begin
    t_on = $time;
    pos = cpha ? -1 : 0;
    drive();
  end
  // launch on the edge opposite the sampling one; skip the load-time polarity move
  always @(sclk) begin
    if (on && $time != t_on && ((sclk != cpol) == cpha)) begin
      pos++;
      drive();
    end
  end
endmodule

// [dv/smf_spi_master_tb.sv]
/*
  Self-checking bench for the four-select serial master.
  Assumes the slave model on the pins and the bound port checker.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module smf_spi_master_tb;
  // ********************************
  // signals and instances
  // ********************************
  localparam logic [31:0] PAT = 32'hc3a5_96e1;
  logic sys_clk, resetn, loopback, char_irq_en, start, tx_valid, tx_ready, rx_valid_q, char_irq_q, busy_q, spi_clk_q;
  logic spi_tx_q, spi_rx;
  logic [smf_pkg::DIV_W-1:0]    clk_div;
  logic [smf_pkg::LEN_W-1:0]    char_len_m1;
  logic [smf_pkg::FRAME_W-1:0]  frame_len_m1;
  logic [smf_pkg::CS_SEL_W-1:0] cs_sel;
  logic [smf_pkg::CS_N-1:0]     cs_active_high, clock_polarity_select, clock_phase_select, slave_select_lines_q;
  logic [smf_pkg::DLY_W-1:0]    cs_delay;
  logic [smf_pkg::DATA_W-1:0]   tx_data, rx_data_q;
  logic [31:0]                  rxq[$];
  int                           err_total, comparisons, irqs;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  smf_spi_master u_smf_spi_master (.sys_clk(sys_clk), .resetn(resetn), .clk_div(clk_div),
    .char_len_m1(char_len_m1), .frame_len_m1(frame_len_m1), .cs_sel(cs_sel), .cs_active_high(cs_active_high),
    .clock_polarity_select(clock_polarity_select), .clock_phase_select(clock_phase_select), .cs_delay(cs_delay),
    .loopback(loopback), .char_irq_en(char_irq_en), .start(start), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .char_irq_q(char_irq_q),
    .busy_q(busy_q), .spi_clk_q(spi_clk_q), .spi_tx_q(spi_tx_q), .slave_select_lines_q(slave_select_lines_q),
    .spi_rx(spi_rx));
  smf_slave_model #(.PAT(PAT)) u_smf_slave_model (.sclk(spi_clk_q), .cs_line(slave_select_lines_q[cs_sel]),
    .act_hi(cs_active_high[cs_sel]), .cpol(clock_polarity_select[cs_sel]), .cpha(clock_phase_select[cs_sel]),
    .len_m1(char_len_m1), .miso(spi_rx));
  always @(posedge sys_clk) begin
    if (rx_valid_q === 1'b1) rxq.push_back(rx_data_q);
    if (char_irq_q === 1'b1) irqs++;
  end

  // ********************************
  // tasks
  // ********************************
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask
  task automatic push(input logic [31:0] w);
    int k;
    tx_data <= w;
    tx_valid <= 1'b1;
    for (k = 0; k < 20000; k++) begin
      @(posedge sys_clk);
      if (tx_ready === 1'b1) break;
    end
    if (k == 20000) timeout();
  endtask
  // one frame; returns cycles from select assert to first clock edge
  task automatic frame(input logic [1:0] sel, mode, input logic [4:0] len, input int n,
                       input logic [1:0] dly, input logic lb, ien, act, output int lead);
    int cyc, t_sel, t_clk, edges, i, nm;
    logic pclk, seen;
    logic [31:0] mask, w[$];
    mask = 32'hffff_ffff >> (5'h1f - len);
    nm = n - 1;
    @(posedge sys_clk);
    cs_sel <= sel;
    char_len_m1 <= len;
    frame_len_m1 <= nm[11:0];
    cs_delay <= dly;
    loopback <= lb;
    char_irq_en <= ien;
    cs_active_high <= act ? (4'h1 << sel) : 4'h0;
    clock_polarity_select <= {4{mode[1]}};
    clock_phase_select <= {4{mode[0]}};
    rxq.delete();
    irqs = 0;
    for (i = 0; i < n; i++) begin
      w.push_back((32'h9e37_79b9 * (i + 3)) & mask);
      push(w[i]);
    end
    tx_valid <= 1'b0;
    if (n > smf_pkg::FIFO_DEPTH) begin
      repeat (2) @(posedge sys_clk);
      `CHK(tx_ready, 1'b0)
      tx_data <= 32'h0dea_d0ff;
      tx_valid <= 1'b1;
      @(posedge sys_clk);
      tx_valid <= 1'b0;
    end
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    seen = 1'b0;
    edges = 0;
    t_clk = -1;
    t_sel = -1;
    for (cyc = 0; cyc < 30000; cyc++) begin
      @(posedge sys_clk);
      if (t_sel < 0 && slave_select_lines_q[sel] === act) t_sel = cyc;
      if (busy_q === 1'b1) begin
        if (seen && spi_clk_q !== pclk) begin
          edges++;
          if (t_clk < 0) t_clk = cyc;
        end
        seen = 1'b1;
        pclk = spi_clk_q;
      end else if (seen) break;
    end
    if (cyc == 30000) timeout();
    lead = t_clk - t_sel;
    `CHK(t_sel, 0)
    `CHK(edges, 2 * (len + 1) * n)
    `CHK(irqs, ien ? n : 0)
    `CHK(rxq.size(), n)
    `CHK(slave_select_lines_q, ~cs_active_high)
    for (i = 0; i < n && i < rxq.size(); i++) `CHK(rxq[i], lb ? w[i] : PAT & mask)
  endtask
  task automatic t_modes();
    int l;
    for (int m = 0; m < 4; m++) frame(m[1:0], m[1:0], 5'h07, 2, 2'h0, 1'b0, m[0], m == 2, l);
  endtask
  task automatic t_loop();
    int l;
    frame(2'h1, 2'h3, 5'h1f, 1, 2'h0, 1'b1, 1'b1, 1'b0, l);
    frame(2'h3, 2'h1, 5'h00, 3, 2'h1, 1'b1, 1'b0, 1'b1, l);
    frame(2'h2, 2'h0, 5'h03, smf_pkg::FIFO_DEPTH + 1, 2'h0, 1'b1, 1'b1, 1'b0, l);
  endtask
  task automatic t_delay();
    int l, l0;
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      clk_div <= 16'h0002 << v;
      for (int d = 0; d < 4; d++) begin
        frame(2'h0, 2'h1, 5'h02, 2, d[1:0], 1'b1, 1'b0, 1'b0, l);
        if (d == 0) l0 = l;
        `CHK(l - l0, 2 * d * (3 + 2 * v))
      end
    end
  endtask

  initial begin
    err_total = 0;
    comparisons = 0;
    irqs = 0;
    resetn = 1'b0;
    start = 1'b0;
    tx_valid = 1'b0;
    tx_data = 32'h0;
    clk_div = 16'h0002;
    char_len_m1 = 5'h07;
    frame_len_m1 = 12'h000;
    cs_sel = 2'h0;
    cs_active_high = 4'h0;
    clock_polarity_select = 4'h0;
    clock_phase_select = 4'h0;
    cs_delay = 2'h0;
    loopback = 1'b0;
    char_irq_en = 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK({slave_select_lines_q, spi_clk_q, spi_tx_q, busy_q, tx_ready}, {smf_pkg::CS_RESET, 4'h1})
    resetn <= 1'b1;
    t_modes();
    t_loop();
    t_delay();
    test_done();
  end
endmodule
